// ===== rtl/sbpdm_pkg.sv
/*
 sbpdm_pkg: constants, register offsets and carrier types for the
 six-bit port data mux.
 Assumes a 32-bit APB slave with word-aligned registers.
*/
package sbpdm_pkg;
   localparam int PORT_W = 6;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_DATA = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_DIR = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PIE = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_IST = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_IMSK = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_PIN = 8'h18;
   // reset values
   localparam logic [PORT_W-1:0] RST_DATA = 6'h00;
   localparam logic [PORT_W-1:0] RST_DIR = 6'h00;
   // pin positions
   localparam int BIT_IRQ = 5;
   localparam int BIT_TRG1 = 5;
   localparam int BIT_TRG0 = 4;
   localparam int BIT_SUPPLY = 2;
   localparam int BIT_NMI = 1;
   // control register fields
   localparam int CTRL_IRQ_EN = 0;
   localparam int CTRL_SUP_EN = 1;
   localparam int CTRL_OC_EN = 2;
   // read-only view of the non-maskable latch
   localparam int CTRL_NMI_LT = 3;
   // status fields: [5:0] pin edge events, [6] over-current
   localparam int IST_OC = 6;
   localparam int IST_W = 7;

   typedef struct packed {
      logic [PORT_W-1:0] out;
      logic [PORT_W-1:0] oe_n;
   } sbpdm_pad_t;

   typedef struct packed {
      logic irq_en;
      logic sup_en;
      logic oc_en;
   } sbpdm_ctrl_t;
endpackage : sbpdm_pkg

// ===== rtl/sbpdm_port.sv
/*
 sbpdm_port: six-bit general-purpose port with alternate-function
 priority, interrupt pin taps, trigger taps and switched supply.
 Assumes an APB master on mclk_i, a PWM block giving per-bit enables
 and levels, and a CPU giving the non-maskable mask bit level.
*/
`timescale 1ns/1ns
// Functional notes
// - GPIO output drives stored data bit
// - read returns data if output, else pin
// - bit 5 level feeds maskable interrupt
// - maskable enable forces bit 5 input
// - maskable function beats PWM and GPIO
// - enabled PWM channel beats GPIO
// - pin interrupts in input or output mode
// - bits 5,4 tap triggers, no side effect
// - bit 1 level feeds non-maskable interrupt
// - first mask clear latches bit 1 input
// - non-maskable function beats PWM and GPIO
// - supply on its own output, not pin bit 2, with over-current interrupt
// - direction 1 output, 0 input
// - PWM forces output, direction unchanged
module sbpdm_port
   import sbpdm_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // pins
   input wire logic [PORT_W-1:0] pin_i,
   output logic [PORT_W-1:0] pin_o,
   output logic [PORT_W-1:0] pin_oe_n_o,
   // pwm channels
   input wire logic [PORT_W-1:0] pwm_en_i,
   input wire logic [PORT_W-1:0] pwm_out_i,
   // cpu mask bit and over-current detector
   input wire logic nmi_mask_i,
   input wire logic over_current_i,
   // taps toward interrupt and trigger logic
   output logic maskable_irq_o,
   output logic nonmaskable_irq_o,
   output logic [1:0] external_trigger_tap_o,
   output logic switched_external_supply_o,
   output logic irq_o
);
   logic [PORT_W-1:0] port_p_data_bits_q;
   logic [PORT_W-1:0] port_p_data_bits_d;
   logic [PORT_W-1:0] port_p_direction_bits_q;
   logic [PORT_W-1:0] port_p_direction_bits_d;
   sbpdm_ctrl_t ctrl_q;
   sbpdm_ctrl_t ctrl_d;
   logic [PORT_W-1:0] pie_q;
   logic [PORT_W-1:0] pie_d;
   logic [IST_W-1:0] ist_q;
   logic [IST_W-1:0] ist_d;
   logic [IST_W-1:0] imsk_q;
   logic [IST_W-1:0] imsk_d;
   logic nmi_latch_q;
   logic nmi_latch_d;
   logic [PORT_W-1:0] pin_prev_q;
   logic [PORT_W-1:0] pin_prev_d;
   logic [PORT_W-1:0] pin_sync;
   logic [PORT_W-1:0] force_in;
   logic [PORT_W-1:0] rd_data;
   logic [31:0] rd_word;
   logic [31:0] prdata_d;
   logic [31:0] prdata_q;
   logic wr_en;
   logic rd_en;
   logic hit;
   logic [IST_W-1:0] ev;
   sbpdm_pad_t pad;

   // match one register offset
   function automatic logic sel(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      sel = (a == off);
   endfunction : sel

   sbpdm_sync u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .d_i(pin_i),
      .q_o(pin_sync)
   );

   // every register is a flop, so no wait states
   assign pready_o = 1'b1;
   assign wr_en = psel_i & penable_i & pwrite_i;
   assign rd_en = psel_i & ~penable_i & ~pwrite_i;

   // forced-input map for the interrupt pins
   always_comb
   begin
      force_in = '0;
      force_in[BIT_IRQ] = ctrl_q.irq_en;
      force_in[BIT_NMI] = nmi_latch_q;
   end

   // forced bits float: the pin is only watched then
   // pad drive, one bit per lane
   genvar gi;
   generate
      for (gi = 0; gi < PORT_W; gi++)
      begin : g_pad
         always_comb
         begin
            if (force_in[gi])
            begin
               pad.out[gi] = 1'b0;
               pad.oe_n[gi] = 1'b1;
            end
            else if (pwm_en_i[gi])
            begin
               pad.out[gi] = pwm_out_i[gi];
               pad.oe_n[gi] = 1'b0;
            end
            else
            begin
               pad.out[gi] = port_p_data_bits_q[gi];
               pad.oe_n[gi] = ~port_p_direction_bits_q[gi];
            end
         end
      end
   endgenerate

   assign pin_o = pad.out;
   assign pin_oe_n_o = pad.oe_n;

   assign maskable_irq_o = ctrl_q.irq_en & pin_sync[BIT_IRQ];
   assign nonmaskable_irq_o = nmi_latch_q & pin_sync[BIT_NMI];
   // trigger taps only observe the pin
   assign external_trigger_tap_o = {pin_sync[BIT_TRG1],
                                    pin_sync[BIT_TRG0]};
   // supply follows enable alone, not driven on pin bit 2
   assign switched_external_supply_o = ctrl_q.sup_en;

   assign rd_data = (port_p_direction_bits_q & port_p_data_bits_q)
                    | (~port_p_direction_bits_q & pin_sync);

   // event sources
   always_comb
   begin
      ev = '0;
      ev[PORT_W-1:0] = pie_q & (pin_sync ^ pin_prev_q);
      ev[IST_OC] = ctrl_q.oc_en & ctrl_q.sup_en & over_current_i;
   end

   always_comb
   begin
      port_p_data_bits_d = port_p_data_bits_q;
      port_p_direction_bits_d = port_p_direction_bits_q;
      ctrl_d = ctrl_q;
      pie_d = pie_q;
      imsk_d = imsk_q;
      ist_d = ist_q;
      // prev and sync both reset low: no false edge
      pin_prev_d = pin_sync;
      // no bus write reaches the latch
      // sticky once mask bit clears
      nmi_latch_d = nmi_latch_q | ~nmi_mask_i;
      if (wr_en)
      begin
         if (sel(paddr_i, OFF_DATA))
         begin
            port_p_data_bits_d = pwdata_i[PORT_W-1:0];
         end
         else if (sel(paddr_i, OFF_DIR))
         begin
            port_p_direction_bits_d = pwdata_i[PORT_W-1:0];
         end
         else if (sel(paddr_i, OFF_CTRL))
         begin
            ctrl_d.irq_en = pwdata_i[CTRL_IRQ_EN];
            ctrl_d.sup_en = pwdata_i[CTRL_SUP_EN];
            ctrl_d.oc_en = pwdata_i[CTRL_OC_EN];
         end
         else if (sel(paddr_i, OFF_PIE))
         begin
            pie_d = pwdata_i[PORT_W-1:0];
         end
         else if (sel(paddr_i, OFF_IST))
         begin
            ist_d = ist_q & ~pwdata_i[IST_W-1:0];
         end
         else if (sel(paddr_i, OFF_IMSK))
         begin
            imsk_d = pwdata_i[IST_W-1:0];
         end
      end
      // set wins over a same-cycle clear
      ist_d = ist_d | ev;
   end

   always_comb
   begin
      hit = 1'b1;
      // upper bits read as zero
      rd_word = '0;
      if (sel(paddr_i, OFF_DATA))
      begin
         rd_word[PORT_W-1:0] = rd_data;
      end
      else if (sel(paddr_i, OFF_DIR))
      begin
         rd_word[PORT_W-1:0] = port_p_direction_bits_q;
      end
      else if (sel(paddr_i, OFF_CTRL))
      begin
         rd_word[CTRL_IRQ_EN] = ctrl_q.irq_en;
         rd_word[CTRL_SUP_EN] = ctrl_q.sup_en;
         rd_word[CTRL_OC_EN] = ctrl_q.oc_en;
         rd_word[CTRL_NMI_LT] = nmi_latch_q;
      end
      else if (sel(paddr_i, OFF_PIE))
      begin
         rd_word[PORT_W-1:0] = pie_q;
      end
      else if (sel(paddr_i, OFF_IST))
      begin
         rd_word[IST_W-1:0] = ist_q;
      end
      else if (sel(paddr_i, OFF_IMSK))
      begin
         rd_word[IST_W-1:0] = imsk_q;
      end
      else if (sel(paddr_i, OFF_PIN))
      begin
         rd_word[PORT_W-1:0] = pin_sync;
      end
      else
      begin
         hit = 1'b0;
      end
   end

   // read data captured in setup, held through access
   always_comb
   begin
      if (rd_en)
      begin
         prdata_d = rd_word;
      end
      else
      begin
         prdata_d = prdata_q;
      end
   end

   // unmapped addresses answer with an error
   assign pslverr_o = psel_i & penable_i & ~hit;
   assign prdata_o = prdata_q;
   assign irq_o = |(ist_q & imsk_q);

   always_ff @(posedge mclk_i)
   begin
      // only reset clears the latch; data also clears on a bus write of zero
      if (rst_i)
      begin
         port_p_data_bits_q <= RST_DATA;
         port_p_direction_bits_q <= RST_DIR;
         ctrl_q <= '0;
         pie_q <= '0;
         ist_q <= '0;
         imsk_q <= '0;
         nmi_latch_q <= 1'b0;
         pin_prev_q <= '0;
         prdata_q <= '0;
      end
      else
      begin
         port_p_data_bits_q <= port_p_data_bits_d;
         port_p_direction_bits_q <= port_p_direction_bits_d;
         ctrl_q <= ctrl_d;
         pie_q <= pie_d;
         ist_q <= ist_d;
         imsk_q <= imsk_d;
         nmi_latch_q <= nmi_latch_d;
         pin_prev_q <= pin_prev_d;
         prdata_q <= prdata_d;
      end
   end
endmodule : sbpdm_port

// ===== rtl/sbpdm_sync.sv
/*
 sbpdm_sync: two-stage synchroniser for the port pin inputs.
 Assumes pins are asynchronous to mclk_i; reset is synchronous.
*/
`timescale 1ns/1ns
module sbpdm_sync
   import sbpdm_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // data
   input wire logic [PORT_W-1:0] d_i,
   output logic [PORT_W-1:0] q_o
);
   logic [PORT_W-1:0] s1_q;
   logic [PORT_W-1:0] s1_d;
   logic [PORT_W-1:0] s2_q;
   logic [PORT_W-1:0] s2_d;

   always_comb
   begin
      s1_d = d_i;
      s2_d = s1_q;
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         s1_q <= '0;
         s2_q <= '0;
      end
      else
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end

   assign q_o = s2_q;
endmodule : sbpdm_sync

// ===== tb/sbpdm_pins.sv
/*
 sbpdm_pins: external circuitry on the six port pins.
 Assumes the port drives a pin while its output enable is low.
*/
`timescale 1ns/1ns
module sbpdm_pins
   import sbpdm_pkg::*;
(
   // port pads
   input wire logic [PORT_W-1:0] dev_out_i,
   input wire logic [PORT_W-1:0] dev_oe_n_i,
   // external drivers, always active
   input wire logic [PORT_W-1:0] ext_val_i,
   output logic [PORT_W-1:0] pin_o
);
   // device wins contention, so no unknown level on the wire
   assign pin_o = (~dev_oe_n_i & dev_out_i) | (dev_oe_n_i & ext_val_i);
endmodule : sbpdm_pins

// ===== tb/sbpdm_port_chk.sv
/*
 sbpdm_port_chk: port assertions for sbpdm_port.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module sbpdm_port_chk
   import sbpdm_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // pins
   input wire logic [PORT_W-1:0] pin_i,
   input wire logic [PORT_W-1:0] pin_o,
   input wire logic [PORT_W-1:0] pin_oe_n_o,
   input wire logic [PORT_W-1:0] pwm_en_i,
   input wire logic [PORT_W-1:0] pwm_out_i,
   // taps
   input wire logic nmi_mask_i,
   input wire logic maskable_irq_o,
   input wire logic nonmaskable_irq_o,
   input wire logic [1:0] external_trigger_tap_o,
   input wire logic irq_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_pwm;
      &(~pwm_en_i | ~pin_oe_n_o | 6'h22) &&
      ((pin_o ^ pwm_out_i) & pwm_en_i & ~pin_oe_n_o) == 6'h00;
   endproperty
   property p_irq_in;
      maskable_irq_o |-> pin_oe_n_o[5];
   endproperty
   property p_irq_lvl;
      maskable_irq_o |-> $past(pin_i[5], 2);
   endproperty
   property p_nmi_in;
      !$past(rst_i) && !$past(nmi_mask_i) |-> pin_oe_n_o[1] [*8];
   endproperty
   property p_nmi_lvl;
      nonmaskable_irq_o |-> $past(pin_i[1], 2);
   endproperty
   property p_trig;
      !$past(rst_i) && !$past(rst_i, 2) |-> external_trigger_tap_o ==
         {$past(pin_i[5], 2), $past(pin_i[4], 2)};
   endproperty
   property p_slverr;
      pslverr_o |-> psel_i && penable_i;
   endproperty
   property p_ready;
      psel_i && penable_i |-> pready_o;
   endproperty
   a_pwm: assert property (p_pwm)
      else $error("pwm channel not on its pin");
   a_irq_in: assert property (p_irq_in)
      else $error("bit 5 not forced to input");
   a_irq_lvl: assert property (p_irq_lvl)
      else $error("maskable tap wrong level");
   a_nmi_in: assert property (p_nmi_in)
      else $error("bit 1 not held as input");
   a_nmi_lvl: assert property (p_nmi_lvl)
      else $error("non-maskable tap wrong level");
   a_trig: assert property (p_trig)
      else $error("trigger taps wrong");
   a_slverr: assert property (p_slverr)
      else $error("error flag outside access");
   a_ready: assert property (p_ready)
      else $error("access not answered");
   c_irq: cover property (irq_o);
   c_mirq: cover property (maskable_irq_o);
   c_nmi: cover property (nonmaskable_irq_o);
endmodule : sbpdm_port_chk
bind sbpdm_port sbpdm_port_chk i_chk (.*);

// ===== tb/six_bit_port_data_mux_test.sv
/*
 six_bit_port_data_mux_test: register-level tests of sbpdm_port.
 Assumes pins are driven by sbpdm_pins and the bound checker.
*/
`timescale 1ns/1ns
module six_bit_port_data_mux_test
   import sbpdm_pkg::*;
;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic nmi_mask_i = 1'b1;
   logic over_current_i = 1'b0;
   logic [ADDR_W-1:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [PORT_W-1:0] pwm_en_i = 6'h00;
   logic [PORT_W-1:0] pwm_out_i = 6'h00;
   logic [PORT_W-1:0] ext = 6'h00;
   logic [31:0] prdata_o;
   logic [31:0] rdat;
   logic [PORT_W-1:0] pin_i, pin_o, pin_oe_n_o;
   logic [1:0] external_trigger_tap_o;
   logic pready_o, pslverr_o, maskable_irq_o, nonmaskable_irq_o;
   logic switched_external_supply_o, irq_o, serr;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   sbpdm_port i_dut (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pwdata_i(pwdata_i),
      .prdata_o(prdata_o),
      .pready_o(pready_o),
      .pslverr_o(pslverr_o),
      .pin_i(pin_i),
      .pin_o(pin_o),
      .pin_oe_n_o(pin_oe_n_o),
      .pwm_en_i(pwm_en_i),
      .pwm_out_i(pwm_out_i),
      .nmi_mask_i(nmi_mask_i),
      .over_current_i(over_current_i),
      .maskable_irq_o(maskable_irq_o),
      .nonmaskable_irq_o(nonmaskable_irq_o),
      .external_trigger_tap_o(external_trigger_tap_o),
      .switched_external_supply_o(switched_external_supply_o),
      .irq_o(irq_o)
   );
   sbpdm_pins i_pins (.dev_out_i(pin_o), .dev_oe_n_i(pin_oe_n_o),
      .ext_val_i(ext), .pin_o(pin_i));
   always #2 mclk_i = ~mclk_i;
   task automatic results;
      if (error_cnt == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      tests_run++;
      if (s !== e)
      begin
         error_cnt++;
         $display("wrong value %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, d);
      @(posedge mclk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= {24'h0, d};
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      rdat = prdata_o;
      serr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(negedge mclk_i);
   endtask : apb
   task automatic rd(input logic [7:0] a, e, input string nm);
      apb(1'b0, a, 8'h00);
      chk(nm, rdat, {24'h0, e});
   endtask : rd
   initial
   begin
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(OFF_DATA, 8'h00, "data"); // data cleared
      rd(OFF_DIR, 8'h00, "dir"); // all inputs
      chk("oe", pin_oe_n_o, 6'h3F); // all inputs
      apb(1'b1, OFF_DIR, 8'h3F);
      apb(1'b1, OFF_DATA, 8'h2A);
      chk("drv", {pin_oe_n_o, pin_o}, 12'h02A); // gpio out
      repeat (3) @(negedge mclk_i);
      rd(OFF_PIN, 8'h2A, "pin"); // synced pins
      @(posedge mclk_i);
      ext <= 6'h30;
      apb(1'b1, OFF_DIR, 8'h0F);
      repeat (3) @(negedge mclk_i);
      rd(OFF_DATA, 8'h3A, "mix"); // mixed readback
      chk("trg", external_trigger_tap_o, 2'h3); // taps
      @(posedge mclk_i);
      pwm_en_i <= 6'h25;
      pwm_out_i <= 6'h21;
      apb(1'b1, OFF_DIR, 8'h00);
      chk("pwm", {pin_oe_n_o, pin_o & 6'h25}, 12'h6A1); // pwm
      rd(OFF_DIR, 8'h00, "dir"); // dir kept
      apb(1'b1, OFF_CTRL, 8'h01);
      repeat (3) @(negedge mclk_i);
      chk("irq", {pin_oe_n_o, maskable_irq_o}, 7'h75);
      @(posedge mclk_i);
      pwm_en_i <= 6'h27;
      ext <= 6'h32;
      @(posedge mclk_i);
      nmi_mask_i <= 1'b0;
      @(posedge mclk_i);
      nmi_mask_i <= 1'b1;
      repeat (3) @(negedge mclk_i);
      chk("nmi", {pin_oe_n_o[1], nonmaskable_irq_o}, 2'h3);
      rd(OFF_CTRL, 8'h09, "ctrl"); // latch kept
      @(posedge mclk_i);
      pwm_en_i <= 6'h00;
      apb(1'b1, OFF_DIR, 8'h08);
      apb(1'b1, OFF_DATA, 8'h00);
      apb(1'b1, OFF_PIE, 8'h08);
      apb(1'b1, OFF_IST, 8'h7F);
      apb(1'b1, OFF_IMSK, 8'h48);
      apb(1'b1, OFF_DATA, 8'h08);
      repeat (4) @(negedge mclk_i);
      chk("pint", irq_o, 1'b1); // output-mode edge
      rd(OFF_IST, 8'h08, "ist"); // event flag
      apb(1'b1, OFF_IMSK, 8'h40);
      repeat (2) @(negedge mclk_i);
      chk("mask", irq_o, 1'b0); // masked
      apb(1'b1, OFF_IST, 8'h08);
      rd(OFF_IST, 8'h00, "w1c"); // cleared
      apb(1'b1, OFF_CTRL, 8'h07);
      @(posedge mclk_i);
      over_current_i <= 1'b1;
      repeat (3) @(negedge mclk_i);
      chk("oc", {switched_external_supply_o, irq_o}, 2'h3); // supply
      @(posedge mclk_i);
      over_current_i <= 1'b0;
      apb(1'b1, OFF_IST, 8'h40);
      rd(OFF_IST, 8'h00, "occlr"); // cleared
      rd(8'h1C, 8'h00, "unmapped");
      chk("slverr", serr, 1'b1);
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(OFF_CTRL, 8'h00, "rst ctrl"); // latch cleared
      apb(1'b1, OFF_DIR, 8'h3F);
      rd(OFF_DATA, 8'h00, "rst data"); // data cleared
      results();
   end
endmodule : six_bit_port_data_mux_test
